// ==== srj_pkg.sv ====
/*
 * Shared constants for the stack, rotate and jump execution unit:
 * opcodes, special direct addresses, reset values and state codes.
 * Assumes an 8-bit data path and a 16-bit program counter.
 */
package srj_pkg;

    // Opcodes
    localparam logic [7:0] OP_OR_TO_MEMORY   = 8'h42;
    localparam logic [7:0] OP_STACK_READ     = 8'hD0;
    localparam logic [7:0] OP_STACK_WRITE    = 8'hC0;
    localparam logic [7:0] OP_SUB_EXIT       = 8'h22;
    localparam logic [7:0] OP_INT_EXIT       = 8'h32;
    localparam logic [7:0] OP_ROT_LEFT       = 8'h23;
    localparam logic [7:0] OP_ROT_LEFT_C     = 8'h33;
    localparam logic [7:0] OP_ROT_RIGHT      = 8'h03;
    localparam logic [7:0] OP_ROT_RIGHT_C    = 8'h13;
    localparam logic [7:0] OP_SET_CARRY      = 8'hD3;
    localparam logic [7:0] OP_SET_BIT        = 8'hD2;
    localparam logic [7:0] OP_SHORT_JUMP     = 8'h80;

    // Direct addresses served inside the unit
    localparam logic [7:0] ADDR_STATUS_WORD  = 8'hD0;
    localparam logic [7:0] ADDR_ACCUMULATOR  = 8'hE0;
    // Bit-addressable low area base and split point
    localparam logic [7:0] BIT_AREA_BASE     = 8'h20;
    localparam logic [7:0] BIT_SFR_SPLIT     = 8'h80;

    // Values after reset
    localparam logic [7:0]  SP_RESET         = 8'h07;
    localparam logic [15:0] PC_RESET         = 16'h0000;
    localparam logic [7:0]  ACC_RESET        = 8'h00;
    localparam logic [6:0]  PSW_HI_RESET     = 7'h00;

    // Instruction lengths in bytes
    localparam logic [15:0] LEN_ONE          = 16'h0001;
    localparam logic [15:0] LEN_TWO          = 16'h0002;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ1 = 2'b01,
        ST_READ2 = 2'b10
    } srj_state_t;

endpackage

// ==== srj_exec_unit.sv ====
/*
 * Execution unit for a subset of an 8-bit controller's instructions:
 * OR into memory, stack read/write, returns, rotates, set carry/bit and
 * the short relative jump. Holds accumulator, status word, stack pointer
 * and program counter. Assumes an asynchronous-read data memory: read
 * data is valid in the same cycle that memRdEn and memAddr are shown.
 */
`timescale 1ns/10ps

// Functional notes
// - Opcode 42h with a direct address ORs the accumulator into that location, two bytes.
// - Opcode D0h with a direct address copies the byte at the stack pointer to that address.
// - After that copy the stack pointer is reduced by one.
// - Opcode C0h first increments the stack pointer, then stores the named byte there.
// - A stack read into the status word keeps parity following the accumulator.
// - Opcode 22h reloads the program counter from the top two stack bytes.
// - Returns read the high byte at the pointer, decrement, read the low byte, decrement.
// - Opcode 32h returns likewise and re-enables interrupts of equal or lower priority.
// - Opcode 23h rotates the accumulator left, bit 7 into bit 0, carry untouched.
// - Opcode 33h rotates left through carry.
// - Opcode 03h rotates the accumulator right, bit 0 into bit 7, carry untouched.
// - Opcode 13h rotates right through carry.
// - Opcode D3h forces carry to one.
// - Opcode D2h with a bit address sets that bit and keeps the rest of the byte.
// - Opcode 80h advances the program counter by two, then adds the offset.
module srj_exec_unit
    import srj_pkg::*;
#(
    parameter int PC_WIDTH = 16
)
(
    input  wire logic          clock,
    input  wire logic          reset,
    input  wire logic          clockEnable,
    input  wire logic          instrValid,
    input  wire logic [7:0]    instrOpcode,
    input  wire logic [7:0]    instrOperand,
    input  wire logic [7:0]    memRdData,
    output logic               busy,
    output logic               instrDone,
    output logic               illegalOpcode,
    output logic               interruptReenable,
    output logic [7:0]         memAddr,
    output logic               memRdEn,
    output logic               memWrEn,
    output logic [7:0]         memWrData,
    output logic [7:0]         accumulator,
    output logic [7:0]         programStatusWord,
    output logic [7:0]         stackTopPointer,
    output logic [15:0]        programCounter
);

    if (PC_WIDTH != 16)
    begin : g_bad_width
        $error("srj_exec_unit supports only a 16-bit program counter");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte holding a bit address
    function automatic logic [7:0] bitByte(input logic [7:0] bitAddr);
        if (bitAddr < BIT_SFR_SPLIT)
            bitByte = BIT_AREA_BASE + {4'h0, bitAddr[6:3]};
        else
            bitByte = {bitAddr[7:3], 3'b000};
    endfunction

    // Direct read, with accumulator and status word served locally
    function automatic logic [7:0] readDirect(input logic [7:0] addr, input logic [7:0] memData,
                                              input logic [7:0] acc, input logic [7:0] program_status_word);
        if (addr == ADDR_ACCUMULATOR)
            readDirect = acc;
        else if (addr == ADDR_STATUS_WORD)
            readDirect = program_status_word;
        else
            readDirect = memData;
    endfunction

    srj_state_t  state_reg;
    logic [7:0]  opcode_reg;
    logic [7:0]  operand_reg;
    logic [7:0]  acc_reg;
    logic [6:0]  pswHi_reg;
    logic        parity_reg;
    logic [7:0]  sp_reg;
    logic [15:0] pc_reg;
    logic [7:0]  memAddr_reg;
    logic        memRdEn_reg;
    logic        memWrEn_reg;
    logic [7:0]  memWrData_reg;
    logic        busy_reg;
    logic        done_reg;
    logic        illegal_reg;
    logic        intReen_reg;

    logic        accept;
    logic [7:0]  pswView;
    logic [7:0]  srcByte;
    logic [7:0]  destAddr;
    logic [7:0]  destValue;
    logic [15:0] jumpTarget;

    assign accept = clockEnable && instrValid && !busy_reg;
    assign pswView = {pswHi_reg, parity_reg};
    assign srcByte = readDirect(memAddr_reg, memRdData, acc_reg, pswView);
    // Sign-extend and add to the advanced counter
    assign jumpTarget = pc_reg + LEN_TWO + {{8{instrOperand[7]}}, instrOperand};

    ////////////////////////////////////////////////////////////////////////
    // Read-modify-write target for the first read cycle
    always_comb
    begin
        destAddr = memAddr_reg;
        destValue = srcByte;
        case (opcode_reg)
            OP_OR_TO_MEMORY: destValue = srcByte | acc_reg;
            OP_STACK_READ:
            begin
                destAddr = operand_reg;
                destValue = memRdData;
            end
            OP_SET_BIT: destValue = srcByte | (8'h01 << operand_reg[2:0]);
            default: destValue = srcByte;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer, architectural state and memory port
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ST_IDLE;
            opcode_reg <= 8'h00;
            operand_reg <= 8'h00;
            acc_reg <= ACC_RESET;
            pswHi_reg <= PSW_HI_RESET;
            parity_reg <= 1'b0;
            sp_reg <= SP_RESET;
            pc_reg <= PC_RESET;
            memAddr_reg <= 8'h00;
            memRdEn_reg <= 1'b0;
            memWrEn_reg <= 1'b0;
            memWrData_reg <= 8'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            illegal_reg <= 1'b0;
            intReen_reg <= 1'b0;
        end
        else if (clockEnable)
        begin
            memRdEn_reg <= 1'b0;
            memWrEn_reg <= 1'b0;
            done_reg <= 1'b0;
            illegal_reg <= 1'b0;
            intReen_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (accept)
                    begin
                        opcode_reg <= instrOpcode;
                        operand_reg <= instrOperand;
                        done_reg <= 1'b1;
                        case (instrOpcode)
                            OP_ROT_LEFT:
                            begin
                                acc_reg <= {acc_reg[6:0], acc_reg[7]};
                                parity_reg <= ^acc_reg;
                                pc_reg <= pc_reg + LEN_ONE;
                            end
                            OP_ROT_LEFT_C:
                            begin
                                acc_reg <= {acc_reg[6:0], pswHi_reg[6]};
                                pswHi_reg[6] <= acc_reg[7];
                                parity_reg <= ^{acc_reg[6:0], pswHi_reg[6]};
                                pc_reg <= pc_reg + LEN_ONE;
                            end
                            OP_ROT_RIGHT:
                            begin
                                acc_reg <= {acc_reg[0], acc_reg[7:1]};
                                parity_reg <= ^acc_reg;
                                pc_reg <= pc_reg + LEN_ONE;
                            end
                            OP_ROT_RIGHT_C:
                            begin
                                acc_reg <= {pswHi_reg[6], acc_reg[7:1]};
                                pswHi_reg[6] <= acc_reg[0];
                                parity_reg <= ^{pswHi_reg[6], acc_reg[7:1]};
                                pc_reg <= pc_reg + LEN_ONE;
                            end
                            OP_SET_CARRY:
                            begin
                                pswHi_reg[6] <= 1'b1;
                                pc_reg <= pc_reg + LEN_ONE;
                            end
                            OP_SHORT_JUMP: pc_reg <= jumpTarget;
                            OP_OR_TO_MEMORY, OP_SET_BIT:
                            begin
                                memAddr_reg <= (instrOpcode == OP_SET_BIT) ?
                                               bitByte(instrOperand) : instrOperand;
                                memRdEn_reg <= 1'b1;
                                busy_reg <= 1'b1;
                                done_reg <= 1'b0;
                                state_reg <= ST_READ1;
                            end
                            OP_STACK_WRITE:
                            begin
                                sp_reg <= sp_reg + 8'h01;
                                memAddr_reg <= instrOperand;
                                memRdEn_reg <= 1'b1;
                                busy_reg <= 1'b1;
                                done_reg <= 1'b0;
                                state_reg <= ST_READ1;
                            end
                            OP_STACK_READ, OP_SUB_EXIT, OP_INT_EXIT:
                            begin
                                memAddr_reg <= sp_reg;
                                memRdEn_reg <= 1'b1;
                                busy_reg <= 1'b1;
                                done_reg <= 1'b0;
                                state_reg <= ST_READ1;
                            end
                            default: illegal_reg <= 1'b1;
                        endcase
                    end
                end
                ST_READ1:
                begin
                    case (opcode_reg)
                        OP_STACK_WRITE:
                        begin
                            memAddr_reg <= sp_reg;
                            memWrData_reg <= srcByte;
                            memWrEn_reg <= 1'b1;
                            pc_reg <= pc_reg + LEN_TWO;
                            busy_reg <= 1'b0;
                            done_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        OP_SUB_EXIT, OP_INT_EXIT:
                        begin
                            pc_reg[15:8] <= memRdData;
                            sp_reg <= sp_reg - 8'h01;
                            memAddr_reg <= sp_reg - 8'h01;
                            memRdEn_reg <= 1'b1;
                            state_reg <= ST_READ2;
                        end
                        default:
                        begin
                            // Internal registers are written here, memory otherwise
                            if (destAddr == ADDR_ACCUMULATOR)
                            begin
                                acc_reg <= destValue;
                                parity_reg <= ^destValue;
                            end
                            else if (destAddr == ADDR_STATUS_WORD)
                                pswHi_reg <= destValue[7:1];
                            else
                            begin
                                memAddr_reg <= destAddr;
                                memWrData_reg <= destValue;
                                memWrEn_reg <= 1'b1;
                            end
                            if (opcode_reg == OP_STACK_READ)
                                sp_reg <= sp_reg - 8'h01;
                            pc_reg <= pc_reg + LEN_TWO;
                            busy_reg <= 1'b0;
                            done_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    endcase
                end
                ST_READ2:
                begin
                    pc_reg[7:0] <= memRdData;
                    sp_reg <= sp_reg - 8'h01;
                    intReen_reg <= (opcode_reg == OP_INT_EXIT);
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign busy = busy_reg;
    assign instrDone = done_reg;
    assign illegalOpcode = illegal_reg;
    assign interruptReenable = intReen_reg;
    assign memAddr = memAddr_reg;
    assign memRdEn = memRdEn_reg;
    assign memWrEn = memWrEn_reg;
    assign memWrData = memWrData_reg;
    assign accumulator = acc_reg;
    assign programStatusWord = pswView;
    assign stackTopPointer = sp_reg;
    assign programCounter = pc_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic inRead1;
    assign inRead1 = clockEnable && (state_reg == ST_READ1);

    a_or_write_data: assert property (inRead1 && opcode_reg == OP_OR_TO_MEMORY &&
        destAddr != ADDR_ACCUMULATOR && destAddr != ADDR_STATUS_WORD
        |=> memWrEn && memWrData == ($past(memRdData) | $past(acc_reg)))
        else $error("OR to memory wrote the wrong value");
    a_pop_copy: assert property (inRead1 && opcode_reg == OP_STACK_READ &&
        operand_reg != ADDR_ACCUMULATOR && operand_reg != ADDR_STATUS_WORD
        |=> memWrEn && memAddr == $past(operand_reg) && memWrData == $past(memRdData))
        else $error("Stack read did not copy the stack byte");
    a_pop_sp_dec: assert property (inRead1 && opcode_reg == OP_STACK_READ
        |=> stackTopPointer == $past(sp_reg) - 8'h01)
        else $error("Stack read did not decrement the pointer");
    a_push_inc: assert property (accept && instrOpcode == OP_STACK_WRITE
        |=> stackTopPointer == $past(sp_reg) + 8'h01)
        else $error("Stack write did not raise the pointer first");
    a_push_order: assert property (inRead1 && opcode_reg == OP_STACK_WRITE
        |=> memWrEn && memAddr == $past(sp_reg) && stackTopPointer == $past(sp_reg)
        && memWrData == $past(srcByte))
        else $error("Stack write order broken");
    a_parity_tracks: assert property (programStatusWord[0] == ^accumulator)
        else $error("Parity does not follow accumulator");
    a_ret_high_byte: assert property (inRead1 && opcode_reg == OP_SUB_EXIT
        |=> programCounter[15:8] == $past(memRdData) && state_reg == ST_READ2)
        else $error("Return high byte not loaded");
    a_ret_low_byte: assert property (clockEnable && state_reg == ST_READ2
        |=> programCounter[7:0] == $past(memRdData)
        && stackTopPointer == $past(sp_reg) - 8'h01 && instrDone)
        else $error("Return low byte not loaded");
    a_interrupt_exit_reenable: assert property (interruptReenable
        |-> instrDone && opcode_reg == OP_INT_EXIT)
        else $error("Interrupt re-enable without interrupt exit");
    a_rot_left: assert property (accept && instrOpcode == OP_ROT_LEFT
        |=> accumulator == {$past(acc_reg[6:0]), $past(acc_reg[7])}
        && programStatusWord[7] == $past(pswHi_reg[6]))
        else $error("Rotate left wrong");
    a_rot_left_c: assert property (accept && instrOpcode == OP_ROT_LEFT_C
        |=> programStatusWord[7] == $past(acc_reg[7]) && accumulator[0] == $past(pswHi_reg[6]))
        else $error("Rotate left through carry wrong");
    a_rot_right: assert property (accept && instrOpcode == OP_ROT_RIGHT
        |=> accumulator == {$past(acc_reg[0]), $past(acc_reg[7:1])})
        else $error("Rotate right wrong");
    a_rot_right_c: assert property (accept && instrOpcode == OP_ROT_RIGHT_C
        |=> programStatusWord[7] == $past(acc_reg[0]) && accumulator[7] == $past(pswHi_reg[6]))
        else $error("Rotate right through carry wrong");
    a_set_carry: assert property (accept && instrOpcode == OP_SET_CARRY
        |=> programStatusWord[7])
        else $error("Carry not set");
    a_set_bit_mask: assert property (inRead1 && opcode_reg == OP_SET_BIT
        && destAddr != ADDR_ACCUMULATOR && destAddr != ADDR_STATUS_WORD
        |=> memWrData == ($past(memRdData) | (8'h01 << $past(operand_reg[2:0]))))
        else $error("Set bit changed other bits");
    a_jump_target: assert property (accept && instrOpcode == OP_SHORT_JUMP
        |=> programCounter == $past(pc_reg) + 16'h0002
        + {{8{$past(instrOperand[7])}}, $past(instrOperand)})
        else $error("Short jump target wrong");

    c_return_done: cover property (clockEnable && state_reg == ST_READ2 ##1 instrDone);
    c_push_write: cover property (memWrEn && opcode_reg == OP_STACK_WRITE);
    c_pop_psw: cover property (inRead1 && opcode_reg == OP_STACK_READ
        && operand_reg == ADDR_STATUS_WORD);
    c_back_jump: cover property (accept && instrOpcode == OP_SHORT_JUMP && instrOperand[7]);

endmodule

// ==== srj_data_memory.sv ====
/*
 * Behavioural model of the internal data memory beside the execution unit.
 * Assumes reads are combinational while memRdEn is high and writes land on
 * the rising edge that ends a cycle with memWrEn high.
 */
`timescale 1ns/10ps

module srj_data_memory
(
    input  wire logic       clock,
    input  wire logic [7:0] memAddr,
    input  wire logic       memRdEn,
    input  wire logic       memWrEn,
    input  wire logic [7:0] memWrData,
    output logic      [7:0] memRdData
);
    logic [7:0] mem [0:255];
    logic [7:0] lastRd;

    ////////////////////////////////////////////////////////////////////////
    // Unselected reads show the inverse of the last byte, never a stale copy
    assign memRdData = memRdEn ? mem[memAddr] : ~lastRd;

    // Write port and last-read tracking
    always @(posedge clock)
    begin
        if (memWrEn)
        begin
            mem[memAddr] <= memWrData;
        end
        if (memRdEn)
        begin
            lastRd <= mem[memAddr];
        end
    end

    initial
    begin
        lastRd = 8'h00;
    end
endmodule

// ==== stack_rotate_jump_exec_test.sv ====
/*
 * Self-checking bench for the execution unit with a data memory model.
 * Assumes the unit accepts one instruction when idle and pulses instrDone.
 */
`timescale 1ns/10ps

module stack_rotate_jump_exec_test;
    import srj_pkg::*;
    logic        clock, reset, instrValid, busy, instrDone, illegalOpcode;
    logic        interruptReenable, memRdEn, memWrEn, sawReen, sawIll;
    logic        clockEnable;
    logic [7:0]  instrOpcode, instrOperand, memRdData, memAddr, memWrData;
    logic [7:0]  accumulator, programStatusWord, stackTopPointer;
    logic [15:0] programCounter;
    int          num_errors, samples_checked;

    srj_exec_unit u_srj_exec_unit (.clock(clock), .reset(reset), .clockEnable(clockEnable),
        .instrValid(instrValid), .instrOpcode(instrOpcode), .instrOperand(instrOperand),
        .memRdData(memRdData), .busy(busy), .instrDone(instrDone),
        .illegalOpcode(illegalOpcode), .interruptReenable(interruptReenable),
        .memAddr(memAddr), .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData),
        .accumulator(accumulator), .programStatusWord(programStatusWord),
        .stackTopPointer(stackTopPointer), .programCounter(programCounter));

    srj_data_memory u_srj_data_memory (.clock(clock), .memAddr(memAddr),
        .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData),
        .memRdData(memRdData));

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison helpers
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Offers one instruction and waits, bounded, for its completion pulse
    task automatic exec(input logic [7:0] op, input logic [7:0] opd, input int lat);
        int i;
        @(posedge clock);
        #1;
        instrValid = 1'b1;
        instrOpcode = op;
        instrOperand = opd;
        @(posedge clock);
        #1;
        instrValid = 1'b0;
        chk("busy", 16'(lat > 1), 16'(busy));
        for (i = 0; i < 8 && instrDone !== 1'b1; i++)
        begin
            @(posedge clock);
            #1;
        end
        sawReen = interruptReenable;
        sawIll = illegalOpcode;
        if (instrDone !== 1'b1)
        begin
            num_errors++;
            $display("wrong value instrDone expected 1 seen %b", instrDone);
            stop_test();
        end
        else
        begin
            chk("latency", 16'(lat - 1), 16'(i));
            // One more edge lets a write issued with the completion land
            @(posedge clock);
            #1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_stack();
        u_srj_data_memory.mem[8'h07] = 8'hF0;
        exec(OP_STACK_READ, ADDR_ACCUMULATOR, 2);
        chk("acc", 16'h00F0, 16'(accumulator));
        chk("sp", 16'h0006, 16'(stackTopPointer));
        u_srj_data_memory.mem[8'h30] = 8'h31;
        exec(OP_OR_TO_MEMORY, 8'h30, 2);
        chk("or byte", 16'h00F1, 16'(u_srj_data_memory.mem[8'h30]));
        exec(OP_STACK_WRITE, 8'h30, 2);
        chk("sp", 16'h0007, 16'(stackTopPointer));
        chk("pushed", 16'h00F1, 16'(u_srj_data_memory.mem[8'h07]));
        chk("pc", 16'h0006, programCounter);
    endtask

    task automatic test_rotates();
        exec(OP_ROT_LEFT, 8'h00, 1);
        chk("acc", 16'h00E1, {7'h00, programStatusWord[7], accumulator});
        exec(OP_ROT_LEFT_C, 8'h00, 1);
        chk("acc", 16'h01C2, {7'h00, programStatusWord[7], accumulator});
        exec(OP_ROT_RIGHT_C, 8'h00, 1);
        chk("acc", 16'h00E1, {7'h00, programStatusWord[7], accumulator});
        exec(OP_ROT_RIGHT, 8'h00, 1);
        chk("acc", 16'h00F0, {7'h00, programStatusWord[7], accumulator});
        exec(OP_SET_CARRY, 8'h00, 1);
        chk("carry", 16'h0001, 16'(programStatusWord[7]));
        chk("pc", 16'h000B, programCounter);
    endtask

    task automatic test_status_bit();
        exec(OP_STACK_READ, ADDR_STATUS_WORD, 2);
        chk("psw", 16'h00F0, 16'(programStatusWord));
        u_srj_data_memory.mem[8'h21] = 8'h46;
        exec(OP_SET_BIT, 8'h0D, 2);
        chk("bit byte", 16'h0066, 16'(u_srj_data_memory.mem[8'h21]));
        chk("pc", 16'h000F, programCounter);
        exec(OP_SET_BIT, 8'hD1, 2);
        chk("psw bit", 16'h00F2, 16'(programStatusWord));
    endtask

    task automatic test_returns();
        u_srj_data_memory.mem[8'h06] = 8'h12;
        u_srj_data_memory.mem[8'h05] = 8'h34;
        exec(OP_SUB_EXIT, 8'h00, 3);
        chk("pc", 16'h1234, programCounter);
        chk("sp", 16'h0004, 16'(stackTopPointer));
        chk("reenable", 16'h0000, 16'(sawReen));
        u_srj_data_memory.mem[8'h04] = 8'h56;
        u_srj_data_memory.mem[8'h03] = 8'h78;
        exec(OP_INT_EXIT, 8'h00, 3);
        chk("pc", 16'h5678, programCounter);
        chk("reenable", 16'h0001, 16'(sawReen));
        chk("sp", 16'h0002, 16'(stackTopPointer));
    endtask

    task automatic test_jump_illegal();
        exec(OP_SHORT_JUMP, 8'hF0, 1);
        chk("pc", 16'h566A, programCounter);
        exec(OP_SHORT_JUMP, 8'h0F, 1);
        chk("pc", 16'h567B, programCounter);
        exec(8'hA5, 8'h00, 1);
        chk("illegal", 16'h0001, 16'(sawIll));
        chk("pc", 16'h567B, programCounter);
    endtask

    // Offers a rotate while the clock enable is low: nothing may move
    task automatic test_freeze();
        @(posedge clock);
        #1;
        clockEnable = 1'b0;
        instrValid = 1'b1;
        instrOpcode = OP_ROT_LEFT;
        repeat (3) @(posedge clock);
        #1;
        chk("frozen pc", 16'h567B, programCounter);
        chk("frozen acc", 16'h00F0, 16'(accumulator));
        chk("frozen done", 16'h0000, 16'(instrDone));
        instrValid = 1'b0;
        clockEnable = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock, reset and main sequence
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial
    begin
        num_errors = 0;
        samples_checked = 0;
        reset = 1'b1;
        clockEnable = 1'b1;
        instrValid = 1'b0;
        instrOpcode = 8'h00;
        instrOperand = 8'h00;
        repeat (12) @(posedge clock);
        #1;
        reset = 1'b0;
        chk("sp", 16'h0007, 16'(stackTopPointer));
        chk("pc", 16'h0000, programCounter);
        test_stack();
        test_rotates();
        test_status_bit();
        test_returns();
        test_jump_illegal();
        test_freeze();
        stop_test();
    end
endmodule
